/* verilog/vsp_pkg.sv */
// Constants and types for the video sync and pixel output block
//
// Overview of operation
// [RQ1] Colour buses are 8 bits, bit 7 MSB
// [RQ2] 10-bit samples rounded to 8-bit words
// [RQ3] Strobe and conversion rate up to 80 MSPS
// [RQ4] Phase setting shifts colour buses with strobe
// [RQ5] Pixel strobe comes from the PLL clock
// [RQ6] Line sync rebuilt internally, aligned to strobe
// [RQ7] Phase setting moves rebuilt line sync too
// [RQ8] Frame sync out from input or separator
// [RQ9] Control state initialised while reset held low
// [RQ10] Line sync polarity set by control bit
// [RQ11] PLL reference uses leading edge only
// [RQ12] Green sync slice may replace line sync
// [RQ13] Hold window derived from frame sync input
// [RQ14] Clamp window derived from line sync input
// [RQ15] Internal clamp gated off during hold
// [RQ16] Controller sets options over two-wire bus
// [RQ17] Green slice result driven on own output
// [RQ18] External hold freezes PLL reference tracking
// [RQ19] External clamp input may replace internal clamp
// [RQ20] Reset asynchronous, defaults before first access
// [RQ21] Capture words and line sync on one edge
package vsp_pkg;

    // -------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ    = 10_000_000;
    localparam int unsigned SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
    localparam int unsigned MAX_RATE_SPS  = 80_000_000;

    // Clamp window after the trailing edge of line sync, least time
    localparam int unsigned CLAMP_TIME_NS = 500;
    localparam int unsigned CLAMP_CYC     =
        (CLAMP_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    // Run length on the green slice that marks a frame sync pulse
    localparam int unsigned SEP_TIME_NS   = 10_000;
    localparam int unsigned SEP_CYC       =
        (SEP_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    // -------------------------------------------------------------
    // Widths and counts
    // -------------------------------------------------------------
    localparam int unsigned SAMPLE_W      = 10;
    localparam int unsigned WORD_W        = 8;
    localparam int unsigned WORD_MSB      = 7;
    localparam int unsigned PHASE_W       = 3;
    localparam int unsigned PHASE_STEPS   = 8;
    localparam int unsigned LINE_SYNC_PIX = 8;
    localparam int unsigned CNT_W         = 8;
    localparam int unsigned LCNT_W        = 4;

    // -------------------------------------------------------------
    // State of each clock domain
    // -------------------------------------------------------------
    typedef struct packed {
        logic [1:0]       line_sy;
        logic [1:0]       frame_sy;
        logic [1:0]       slice_sy;
        logic [1:0]       xhold_sy;
        logic [1:0]       xclamp_sy;
        logic             line_prev;
        logic [CNT_W-1:0] clamp_cnt;
        logic [CNT_W-1:0] run_cnt;
        logic             slice_prev;
        logic             sep;
        logic             hold;
        logic             clamp;
        logic             frame_out;
        logic             slice_out;
    } vsp_sys_st_t;

    typedef struct packed {
        logic [1:0]              line_sy;
        logic [1:0]              slice_sy;
        logic [1:0]              pol_sy;
        logic [1:0]              src_sy;
        logic [1:0]              hold_sy;
        logic [1:0][PHASE_W-1:0] phase_sy;
        logic [PHASE_W-1:0]      phase_cmp;
        logic [PHASE_W-1:0]      phase;
        logic                    act_prev;
        logic [LCNT_W-1:0]       regen_cnt;
        logic                    regen;
        logic                    pll_ref;
        logic                    valid;
        logic [WORD_W-1:0]       red;
        logic [WORD_W-1:0]       grn;
        logic [WORD_W-1:0]       blu;
    } vsp_pix_st_t;

endpackage : vsp_pkg

/* verilog/vsp_phase_delay.sv */
// Selectable delay line that shifts strobe, words and line sync together
`timescale 1ns/100ps
module vsp_phase_delay
    import vsp_pkg::*;
#(
    parameter int unsigned WIDTH = 26,
    parameter int unsigned DEPTH = PHASE_STEPS
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire logic [$clog2(DEPTH)-1:0] i_sel,
    input  wire logic [WIDTH-1:0]         i_data,
    output logic      [WIDTH-1:0]         o_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] taps;
        logic [WIDTH-1:0]            out;
    } vsp_dly_st_t;

    vsp_dly_st_t s_q;
    vsp_dly_st_t s_d;

    // -------------------------------------------------------------
    // One tap per phase step; every field takes the same tap
    // -------------------------------------------------------------
    always_comb begin
        s_d         = s_q;
        s_d.taps[0] = i_data;
        for (int i = 1; i < DEPTH; i++) begin
            s_d.taps[i] = s_q.taps[i-1];
        end
        s_d.out = s_q.taps[i_sel];  // RQ4
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_data = s_q.out;

    // Output follows the selected tap one cycle later, whatever the field
    a_tap_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RQ7
        $stable(i_sel) |=> o_data == $past(s_q.taps[i_sel]))
        else $error("delayed output does not follow selected tap");

endmodule : vsp_phase_delay

/* verilog/vsp_sync_out.sv */
// Sync processing and pixel output: hold, clamp, line and frame sync, words
`timescale 1ns/100ps
module vsp_sync_out
    import vsp_pkg::*;
(
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst_n,
    input  wire logic                i_clk_pix,
    input  wire logic                i_line_sync,
    input  wire logic                i_frame_sync,
    input  wire logic                i_green_sync_in,
    input  wire logic                i_ext_hold,
    input  wire logic                i_ext_clamp,
    input  wire logic                i_sample_valid,
    input  wire logic [SAMPLE_W-1:0] i_red_sample,
    input  wire logic [SAMPLE_W-1:0] i_green_sample,
    input  wire logic [SAMPLE_W-1:0] i_blue_sample,
    // Options arrive as plain levels from the two-wire register side
    input  wire logic                i_line_sync_active_low,  // RQ16
    input  wire logic                i_use_green_sync,
    input  wire logic                i_frame_from_separator,
    input  wire logic                i_hold_internal,
    input  wire logic                i_clamp_external,
    input  wire logic [PHASE_W-1:0]  i_phase_adjust,
    output logic                     o_pixel_strobe,
    output logic [WORD_W-1:0]        o_red_word_out,
    output logic [WORD_W-1:0]        o_green_word_out,
    output logic [WORD_W-1:0]        o_blue_word_out,
    output logic                     o_line_sync_out,
    output logic                     o_frame_sync_out,
    output logic                     o_green_sync_slice_out,
    output logic                     o_pll_ref,
    output logic                     o_pll_hold,
    output logic                     o_clamp
);

    localparam logic [CNT_W-1:0]  CLAMP_LOAD = CNT_W'(CLAMP_CYC);
    localparam logic [CNT_W-1:0]  SEP_LOAD   = CNT_W'(SEP_CYC);
    localparam logic [LCNT_W-1:0] LINE_LOAD  = LCNT_W'(LINE_SYNC_PIX);
    localparam int unsigned       DLY_W      = 2 + 3 * WORD_W;

    // Round a 10-bit sample to the 8-bit word, saturating at full scale
    function automatic logic [WORD_W-1:0] reduce_word(
        input logic [SAMPLE_W-1:0] smp
    );
        logic [SAMPLE_W:0] sum;
        sum = {1'b0, smp} + (SAMPLE_W+1)'(2);
        if (sum[SAMPLE_W]) begin
            reduce_word = {WORD_W{1'b1}};
        end else begin
            reduce_word = sum[SAMPLE_W-1:SAMPLE_W-WORD_W];
        end
    endfunction : reduce_word

    // Leading edge of a sync level given its previous value
    function automatic logic lead_edge(input logic now_v, input logic prev_v);
        lead_edge = now_v & ~prev_v;
    endfunction : lead_edge

    // -------------------------------------------------------------
    // System domain: hold, clamp, frame sync and slice output
    // -------------------------------------------------------------
    vsp_sys_st_t ss_q;
    vsp_sys_st_t ss_d;
    logic        sys_line_act;
    logic        sys_src;

    always_comb begin
        ss_d               = ss_q;
        ss_d.line_sy       = {ss_q.line_sy[0], i_line_sync};
        ss_d.frame_sy      = {ss_q.frame_sy[0], i_frame_sync};
        ss_d.slice_sy      = {ss_q.slice_sy[0], i_green_sync_in};
        ss_d.xhold_sy      = {ss_q.xhold_sy[0], i_ext_hold};
        ss_d.xclamp_sy     = {ss_q.xclamp_sy[0], i_ext_clamp};

        sys_line_act       = ss_q.line_sy[1] ^ i_line_sync_active_low;  // RQ10
        sys_src            = i_use_green_sync ? ss_q.slice_sy[1]
                                              : sys_line_act;  // RQ12
        ss_d.line_prev     = sys_src;

        // Clamp starts on the trailing edge so it lands on the back porch
        if (ss_q.line_prev && !sys_src) begin
            ss_d.clamp_cnt = CLAMP_LOAD;  // RQ14
        end else if (ss_q.clamp_cnt != '0) begin
            ss_d.clamp_cnt = ss_q.clamp_cnt - CNT_W'(1);
        end

        // Hold from the frame sync level or from the external pin
        ss_d.hold = i_hold_internal ? ss_q.frame_sy[1]  // RQ13
                                    : ss_q.xhold_sy[1];  // RQ18

        if (i_clamp_external) begin
            ss_d.clamp = ss_q.xclamp_sy[1];  // RQ19
        end else begin
            ss_d.clamp = (ss_q.clamp_cnt != '0) && !ss_q.hold;  // RQ15
        end

        // Separator: a long slice run sets the frame level it has shown
        ss_d.slice_prev = ss_q.slice_sy[1];
        if (ss_q.slice_sy[1] != ss_q.slice_prev) begin
            ss_d.run_cnt = '0;
        end else if (ss_q.run_cnt != SEP_LOAD) begin
            ss_d.run_cnt = ss_q.run_cnt + CNT_W'(1);
        end
        if (ss_q.run_cnt == SEP_LOAD) begin
            ss_d.sep = ss_q.slice_prev;
        end

        ss_d.frame_out = i_frame_from_separator ? ss_q.sep
                                                : ss_q.frame_sy[1];  // RQ8
        ss_d.slice_out = ss_q.slice_sy[1];  // RQ17
    end

    // Control state takes defaults the moment reset falls
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ss_q <= '0;  // RQ9 RQ20
        end else begin
            ss_q <= ss_d;
        end
    end

    assign o_clamp                = ss_q.clamp;
    assign o_frame_sync_out       = ss_q.frame_out;
    assign o_green_sync_slice_out = ss_q.slice_out;

    // -------------------------------------------------------------
    // Link domain reset: asserted at once, released on the pixel clock
    // -------------------------------------------------------------
    logic [1:0] rst_pix_q;
    logic       rst_pix_n;

    always_ff @(posedge i_clk_pix or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_pix_q <= 2'h0;
        end else begin
            rst_pix_q <= {rst_pix_q[0], 1'b1};
        end
    end

    assign rst_pix_n = rst_pix_q[1];

    // -------------------------------------------------------------
    // Link domain: PLL reference, rebuilt line sync, colour words
    // -------------------------------------------------------------
    vsp_pix_st_t       ps_q;
    vsp_pix_st_t       ps_d;
    logic              pix_act;
    logic              pix_lead;
    logic [DLY_W-1:0]  dly_in;
    logic [DLY_W-1:0]  dly_out;

    always_comb begin
        ps_d          = ps_q;
        ps_d.line_sy  = {ps_q.line_sy[0], i_line_sync};
        ps_d.slice_sy = {ps_q.slice_sy[0], i_green_sync_in};
        ps_d.pol_sy   = {ps_q.pol_sy[0], i_line_sync_active_low};
        ps_d.src_sy   = {ps_q.src_sy[0], i_use_green_sync};
        ps_d.hold_sy  = {ps_q.hold_sy[0], ss_q.hold};

        // Phase word is taken only once two samples of it agree
        ps_d.phase_sy  = {ps_q.phase_sy[0], i_phase_adjust};
        ps_d.phase_cmp = ps_q.phase_sy[1];
        if (ps_q.phase_sy[1] == ps_q.phase_cmp) begin
            ps_d.phase = ps_q.phase_cmp;
        end

        pix_act = ps_q.src_sy[1] ? ps_q.slice_sy[1]  // RQ12
                                 : ps_q.line_sy[1] ^ ps_q.pol_sy[1];  // RQ10
        ps_d.act_prev = pix_act;
        pix_lead      = lead_edge(pix_act, ps_q.act_prev);  // RQ11

        // While held the PLL sees no reference and free-runs
        ps_d.pll_ref = pix_lead && !ps_q.hold_sy[1];  // RQ18

        // Rebuilt line sync: fixed width timed in pixels from the lead
        if (pix_lead) begin
            ps_d.regen_cnt = LINE_LOAD;  // RQ6
        end else if (ps_q.regen_cnt != '0) begin
            ps_d.regen_cnt = ps_q.regen_cnt - LCNT_W'(1);
        end
        ps_d.regen = (ps_d.regen_cnt != '0);

        ps_d.valid = i_sample_valid;
        if (i_sample_valid) begin
            ps_d.red = reduce_word(i_red_sample);  // RQ2
            ps_d.grn = reduce_word(i_green_sample);
            ps_d.blu = reduce_word(i_blue_sample);
        end
    end

    // One word per pixel clock, so the block keeps pace at the full rate
    always_ff @(posedge i_clk_pix or negedge rst_pix_n) begin  // RQ3
        if (!rst_pix_n) begin
            ps_q <= '0;
        end else begin
            ps_q <= ps_d;
        end
    end

    assign o_pll_ref  = ps_q.pll_ref;
    assign o_pll_hold = ps_q.hold_sy[1];  // RQ18

    // -------------------------------------------------------------
    // Phase shift: strobe, words and line sync share one delay line
    // -------------------------------------------------------------
    // Strobe is a one-cycle pulse on the PLL clock per new word, so a
    // capture on its edge sees words and line sync together.
    assign dly_in = {ps_q.valid, ps_q.regen, ps_q.red, ps_q.grn, ps_q.blu};

    vsp_phase_delay #(
        .WIDTH (DLY_W),
        .DEPTH (PHASE_STEPS)
    ) u_phase_delay (
        .i_clk   (i_clk_pix),
        .i_rst_n (rst_pix_n),
        .i_sel   (ps_q.phase),  // RQ4 RQ7
        .i_data  (dly_in),
        .o_data  (dly_out)
    );

    assign o_pixel_strobe   = dly_out[DLY_W-1];  // RQ5
    assign o_line_sync_out  = dly_out[DLY_W-2];  // RQ6 RQ7
    assign o_red_word_out   = dly_out[3*WORD_W-1:2*WORD_W];  // RQ1
    assign o_green_word_out = dly_out[2*WORD_W-1:WORD_W];
    assign o_blue_word_out  = dly_out[WORD_W-1:0];

    // -------------------------------------------------------------
    // Checks, system domain
    // -------------------------------------------------------------
    a_clamp_gated: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)  // RQ15
        $past(ss_q.hold) && !$past(i_clamp_external) |-> !o_clamp)
        else $error("internal clamp active during hold");

    a_clamp_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)  // RQ14
        ss_q.line_prev && !ss_d.line_prev |=> ss_q.clamp_cnt == CLAMP_LOAD)
        else $error("clamp window not loaded on trailing edge");

    a_frame_select: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)  // RQ8
        !$past(i_frame_from_separator) |-> o_frame_sync_out == $past(ss_q.frame_sy[1]))
        else $error("frame sync output does not follow input");

    a_slice_output: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)  // RQ17
        ##1 ss_q.slice_sy[1] |=> o_green_sync_slice_out ##1 1'b1)
        else $error("slice output does not follow comparator");

    a_hold_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)  // RQ13
        $past(i_hold_internal) |-> ss_q.hold == $past(ss_q.frame_sy[1]))
        else $error("hold does not follow frame sync");

    // -------------------------------------------------------------
    // Checks, link domain
    // -------------------------------------------------------------
    a_ref_leading: assert property (@(posedge i_clk_pix) disable iff (!rst_pix_n)  // RQ11
        o_pll_ref |-> $past(ps_q.act_prev) == 1'b0 && $past(pix_act))
        else $error("reference pulse not on leading edge");

    a_ref_held: assert property (@(posedge i_clk_pix) disable iff (!rst_pix_n)  // RQ18
        $past(ps_q.hold_sy[1]) |-> !o_pll_ref)
        else $error("reference pulse while held");

    a_regen_width: assert property (@(posedge i_clk_pix) disable iff (!rst_pix_n)  // RQ6
        $rose(ps_q.regen) |-> ps_q.regen [*8])
        else $error("rebuilt line sync shorter than its width");

    a_word_round: assert property (@(posedge i_clk_pix) disable iff (!rst_pix_n)  // RQ2
        ps_q.valid |-> ps_q.red == reduce_word($past(i_red_sample))
                    && ps_q.blu == reduce_word($past(i_blue_sample)))
        else $error("colour word is not the rounded sample");

    a_words_on_strobe: assert property (@(posedge i_clk_pix) disable iff (!rst_pix_n)  // RQ1 RQ4
        $changed(o_green_word_out) |-> o_pixel_strobe)
        else $error("colour word changed without strobe");

endmodule : vsp_sync_out

/* verif/vsp_capture_model.sv */
// Display-side capture model: takes words on the pixel strobe and line sync on every pixel clock
`timescale 1ns/100ps
module vsp_capture_model
    import vsp_pkg::*;
(
    input  wire logic                i_clk_pix,
    input  wire logic                i_strobe,
    input  wire logic [WORD_W-1:0]   i_red,
    input  wire logic [WORD_W-1:0]   i_green,
    input  wire logic [WORD_W-1:0]   i_blue,
    input  wire logic                i_line_sync,
    output logic                     o_got,
    output logic [3*WORD_W-1:0]      o_word,
    output logic                     o_line_sync
);
    // Same edge for words and line sync, so their alignment is kept
    always_ff @(posedge i_clk_pix) begin
        o_got       <= i_strobe;
        o_line_sync <= i_line_sync;
        if (i_strobe) begin
            o_word <= {i_red, i_green, i_blue};
        end
    end
endmodule : vsp_capture_model

/* verif/vsp_sync_out_tb.sv */
// Self-checking bench for the sync processing and pixel output block
`timescale 1ns/100ps
module vsp_sync_out_tb
    import vsp_pkg::*;
;
    logic clk_sys, clk_pix, rst_n, line, frame, green, ehold, eclamp, valid;
    logic pol_lo, use_g, sep_sel, hold_int, clamp_ext;
    logic [SAMPLE_W-1:0] rs, gs, bs;
    logic [PHASE_W-1:0]  phase;
    logic strobe, lso, fso, slo, pref, phold, clamp, cap_got;
    logic [WORD_W-1:0]   rw, gw, bw;
    logic [3*WORD_W-1:0] cap_word, exp_q[$];
    logic [15:0]         seed;
    int error_cnt, samples_checked, ref_cnt, clamp_cnt, n, d, w, n0, d0;

    vsp_sync_out u_vsp_sync_out (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_clk_pix(clk_pix),
        .i_line_sync(line), .i_frame_sync(frame), .i_green_sync_in(green),
        .i_ext_hold(ehold), .i_ext_clamp(eclamp), .i_sample_valid(valid),
        .i_red_sample(rs), .i_green_sample(gs), .i_blue_sample(bs),
        .i_line_sync_active_low(pol_lo), .i_use_green_sync(use_g),
        .i_frame_from_separator(sep_sel), .i_hold_internal(hold_int),
        .i_clamp_external(clamp_ext), .i_phase_adjust(phase), .o_pixel_strobe(strobe),
        .o_red_word_out(rw), .o_green_word_out(gw), .o_blue_word_out(bw),
        .o_line_sync_out(lso), .o_frame_sync_out(fso), .o_green_sync_slice_out(slo),
        .o_pll_ref(pref), .o_pll_hold(phold), .o_clamp(clamp));

    vsp_capture_model u_vsp_capture_model (.i_clk_pix(clk_pix), .i_strobe(strobe),
        .i_red(rw), .i_green(gw), .i_blue(bw), .i_line_sync(lso), .o_got(cap_got),
        .o_word(cap_word), .o_line_sync());

    // ---------------------------------------------------------------
    // Clocks, counters and result watcher
    // ---------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Link clock offset so the two domains never share edges
    initial begin
        clk_pix = 1'b0;
        #3;
        forever #7.5 clk_pix = ~clk_pix;
    end
    always @(negedge clk_pix) begin
        if (pref === 1'b1) begin
            ref_cnt++;
        end
        if (cap_got === 1'b1) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("Error words expected none seen %h", cap_word);
            end else begin
                chk("words", exp_q.pop_front(), cap_word);
            end
        end
    end
    always @(negedge clk_sys) begin
        if (clamp === 1'b1) begin
            clamp_cnt++;
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Round to 8 bits, saturating where the carry would overflow
    function automatic logic [WORD_W-1:0] rnd(input logic [SAMPLE_W-1:0] s);
        logic [SAMPLE_W:0] t;
        t = {1'b0, s} + 11'h002;
        return t[SAMPLE_W] ? 8'hff : t[SAMPLE_W-1:2];
    endfunction : rnd

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic sys_wait(input int k);
        repeat (k) @(negedge clk_sys);
    endtask : sys_wait

    task automatic pix_wait(input int k);
        repeat (k) @(negedge clk_pix);
    endtask : pix_wait

    task automatic send(input logic [SAMPLE_W-1:0] r, g, b);
        @(negedge clk_pix);
        rs = r;
        gs = g;
        bs = b;
        valid = 1'b1;
        exp_q.push_back({rnd(r), rnd(g), rnd(b)});
    endtask : send

    task automatic lat_word(output int k);
        send(10'h100, 10'h200, 10'h3ff);
        @(negedge clk_pix);
        valid = 1'b0;
        k = 1;
        while (strobe !== 1'b1 && k < 40) begin
            @(negedge clk_pix);
            k++;
        end
    endtask : lat_word

    // Distance from reference pulse to rebuilt sync, then its width
    task automatic lat_line(output int dd, output int ww);
        dd = 0;
        ww = 0;
        @(negedge clk_pix);
        line = ~pol_lo;
        while (pref !== 1'b1 && dd < 40) begin
            @(negedge clk_pix);
            dd++;
        end
        dd = 0;
        while (lso !== 1'b1 && dd < 40) begin
            @(negedge clk_pix);
            dd++;
        end
        while (lso === 1'b1 && ww < 40) begin
            @(negedge clk_pix);
            ww++;
        end
        line = pol_lo;
    endtask : lat_line

    task automatic pulse_line;
        line = ~pol_lo;
        sys_wait(5);
        line = pol_lo;
        sys_wait(10);
    endtask : pulse_line

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        #1_000_000;
        error_cnt++;
        finish_test();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {rst_n, line, frame, green, ehold, eclamp, valid, pol_lo} = 8'h00;
        {use_g, sep_sel, hold_int, clamp_ext} = 4'h0;
        {rs, gs, bs} = '0;
        phase = '0;
        seed = 16'h0055;
        sys_wait(20);
        rst_n = 1'b1;
        sys_wait(5);
        for (int i = 0; i < 40; i++) begin
            seed = lfsr_next(seed);
            send(seed[9:0], seed[15:6], ~seed[9:0]);
        end
        send(10'h3fe, 10'h001, 10'h002);
        @(negedge clk_pix);
        valid = 1'b0;
        pix_wait(30);
        chk("pending", 0, exp_q.size());
        for (int p = 0; p < PHASE_STEPS; p++) begin
            @(negedge clk_pix);
            phase = p[PHASE_W-1:0];
            pix_wait(12);
            lat_word(n);
            lat_line(d, w);
            if (p == 0) begin
                n0 = n;
                d0 = d;
            end
            chk("word_lat", n0 + p, n);
            chk("line_lat", d0 + p, d);
            chk("line_width", LINE_SYNC_PIX, w);
        end
        for (int k = 0; k < 2; k++) begin
            sys_wait(1);
            pol_lo = k[0];
            line = k[0];
            sys_wait(12);
            ref_cnt = 0;
            clamp_cnt = 0;
            line = ~k[0];
            sys_wait(5);
            chk("ref_lead", 1, ref_cnt);
            line = k[0];
            sys_wait(10);
            chk("ref_trail", 1, ref_cnt);
            chk("clamp_len", CLAMP_CYC, clamp_cnt);
        end
        hold_int = 1'b1;
        frame = 1'b1;
        sys_wait(10);
        chk("hold_int", 1, phold);
        chk("frame_pin", 1, fso);
        ref_cnt = 0;
        clamp_cnt = 0;
        pulse_line();
        chk("ref_held", 0, ref_cnt);
        chk("clamp_held", 0, clamp_cnt);
        {hold_int, frame, ehold} = 3'b001;
        sys_wait(10);
        chk("hold_ext", 1, phold);
        ehold = 1'b0;
        use_g = 1'b1;
        sys_wait(10);
        ref_cnt = 0;
        green = 1'b1;
        sys_wait(5);
        chk("slice_out", 1, slo);
        chk("ref_green", 1, ref_cnt);
        sys_wait(120);
        sep_sel = 1'b1;
        sys_wait(5);
        chk("frame_sep", 1, fso);
        green = 1'b0;
        sys_wait(5);
        chk("slice_low", 0, slo);
        {use_g, sep_sel, clamp_ext, eclamp} = 4'h3;
        sys_wait(5);
        chk("clamp_ext", 1, clamp);
        ehold = 1'b1;
        sys_wait(5);
        rst_n = 1'b0;
        #10;
        chk("rst_clamp", 0, clamp);
        chk("rst_hold", 0, phold);
        sys_wait(20);
        rst_n = 1'b1;
        sys_wait(10);
        chk("clamp_again", 1, clamp);
        {eclamp, ehold} = 2'b00;
        sys_wait(5);
        chk("clamp_off", 0, clamp);
        finish_test();
    end
endmodule : vsp_sync_out_tb
